//--- logic/prescale_if.sv
`timescale 1ns/1ps
interface prescale_if;
    logic tick;
    modport source (output tick);
    modport sink   (input  tick);
endinterface : prescale_if

//--- logic/software_fault_watchdog.sv
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module software_fault_watchdog
    import watchdog_pkg::*;
#(
    parameter int PRESCALE_CYCLES = PRESCALE_DEFAULT
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        halt_exec,
    input  wire logic        ext_irq_wake,
    input  wire logic        osc_irq_wake,
    input  wire logic        rtc_irq_enable,
    input  wire logic        hw_watchdog_option,
    input  wire logic        halt_reset_option,
    input  wire logic        startup_long_select,
    input  wire logic        reset_pin_i,
    output logic             reset_pin_o,
    output logic             reset_pin_oe,
    output logic             watchdog_halted
);

    localparam logic [4:0]  PULSE_LAST    = 5'(RESET_PULSE_CYCLES - 1);
    localparam logic [12:0] STARTUP_S_END = 13'(STARTUP_SHORT - 1);
    localparam logic [12:0] STARTUP_L_END = 13'(STARTUP_LONG - 1);

    // Tick spacing helper counts in 16 bits
    if (PRESCALE_CYCLES < 2 || PRESCALE_CYCLES > 65536) begin : g_bad_prescale
        $error("prescale length out of range");
    end

    prescale_if pre ();

    watchdog_prescaler #(
        .PRESCALE_CYCLES (PRESCALE_CYCLES)
    ) u_prescaler (
        .clock (clock),
        .rst   (rst),
        .pre   (pre)
    );

    function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] target);
        addr_hit = (adr[7:2] == target[7:2]);
    endfunction : addr_hit

    logic [6:0]  counter;
    logic        activate;
    state_type   state;
    logic [12:0] startup_count;
    logic [4:0]  pulse_count;
    logic        pin_meta;
    logic        pin_sync;
    logic        active;
    logic        bus_write;
    logic        ctrl_write;
    logic        sw_reset;
    logic        expire;
    logic        halt_reset;
    logic        fire;
    logic        counting;
    logic        startup_done;
    logic [7:0]  ctrl_view;
    logic [7:0]  status_view;

    // Hardware option overrides the software bit entirely
    assign active       = activate | hw_watchdog_option;
    assign bus_write    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign ctrl_write   = bus_write & wb_sel_i[0] & addr_hit(wb_adr_i, CTRL_ADDR);
    // Deliberate reset: top bit written low, with activation or while already active
    assign sw_reset     = ctrl_write & ~wb_dat_i[TOP_BIT]
                        & (wb_dat_i[ACTIVATE_BIT] | active);
    // Only running state may expire; halt after one step cannot
    assign expire       = pre.tick & (state == st_run) & active & ~ctrl_write
                        & (counter == COUNTER_TRIGGER);
    // Halt with reset option replaces halt by a reset when active and rtc_irq_enable is low
    assign halt_reset   = halt_exec & (state == st_run) & ~rtc_irq_enable
                        & halt_reset_option & active;
    assign fire         = expire | sw_reset | halt_reset;
    // Slow and wait modes have no input here, so they cannot stop it
    assign counting     = (state == st_run) | (state == st_halt_once);
    assign startup_done = startup_long_select ? (startup_count == STARTUP_L_END)
                                              : (startup_count == STARTUP_S_END);
    assign ctrl_view    = {active, counter};
    assign status_view  = {3'h0, reset_pin_oe, pin_sync, (state == st_startup),
                           watchdog_halted, active};

    // Reset pin level, only for software visibility
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= reset_pin_i;
            pin_sync <= pin_meta;
        end
    end

    // Single-cycle classic slave; unmapped reads return zero
    always_ff @(posedge clock) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
                if (addr_hit(wb_adr_i, CTRL_ADDR)) begin
                    wb_dat_o <= {24'h0, ctrl_view};
                end else if (addr_hit(wb_adr_i, STATUS_ADDR)) begin
                    wb_dat_o <= {24'h0, status_view};
                end else begin
                    wb_dat_o <= 32'h0;
                end
            end
        end
    end

    // Activation: set by software only, cleared by reset only
    always_ff @(posedge clock) begin
        if (rst) begin
            activate <= CTRL_RESET[ACTIVATE_BIT];
        end else if (ctrl_write & wb_dat_i[ACTIVATE_BIT]) begin
            activate <= 1'b1;
        end
    end

    // Write loads all seven bits; prescaler phase untouched
    always_ff @(posedge clock) begin
        if (rst) begin
            counter <= CTRL_RESET[6:0];
        end else if (ctrl_write) begin
            counter <= wb_dat_i[6:0];
        end else if (pre.tick & counting) begin
            counter <= counter - 7'h01;
        end
    end

    // Halt handling; halt requests outside running state are ignored
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= st_startup;
        end else begin
            case (state)
                st_startup: begin
                    if (startup_done) begin
                        state <= st_run;
                    end
                end
                st_run: begin
                    if (halt_exec & ~halt_reset) begin
                        state <= rtc_irq_enable ? st_active_halt : st_halt_once;
                    end
                end
                st_halt_once: begin
                    if (ext_irq_wake) begin
                        state <= st_startup;
                    end else if (pre.tick) begin
                        state <= st_halted;
                    end
                end
                st_halted: begin
                    if (ext_irq_wake) begin
                        state <= st_startup;
                    end
                end
                st_active_halt: begin
                    if (ext_irq_wake | osc_irq_wake) begin
                        state <= st_run;
                    end
                end
                default: begin
                    state <= st_startup;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            startup_count <= 13'h0;
        end else if (state == st_startup) begin
            startup_count <= startup_done ? 13'h0 : startup_count + 13'h0001;
        end else begin
            startup_count <= 13'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            watchdog_halted <= 1'b0;
        end else begin
            watchdog_halted <= (state == st_halt_once) | (state == st_halted)
                             | (state == st_active_halt);
        end
    end

    // Reset pulse; a new cause during a pulse is absorbed by it
    always_ff @(posedge clock) begin
        if (rst) begin
            reset_pin_oe <= 1'b0;
            pulse_count  <= 5'h0;
        end else if (reset_pin_oe) begin
            if (pulse_count == PULSE_LAST) begin
                reset_pin_oe <= 1'b0;
                pulse_count  <= 5'h0;
            end else begin
                pulse_count <= pulse_count + 5'h01;
            end
        end else if (fire) begin
            reset_pin_oe <= 1'b1;
            pulse_count  <= 5'h0;
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge clock) begin
        if (rst) begin
            reset_pin_o <= 1'b0;
        end else begin
            reset_pin_o <= 1'b0;
        end
    end

    // Helper: cycles since the last prescaler tick
    logic [15:0] since_tick;
    logic        tick_seen;

    always_ff @(posedge clock) begin
        if (rst) begin
            since_tick <= 16'h0;
            tick_seen  <= 1'b0;
        end else if (pre.tick) begin
            since_tick <= 16'h0;
            tick_seen  <= 1'b1;
        end else begin
            since_tick <= since_tick + 16'h0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_plain_halt;
        (state == st_run) && halt_exec && !rtc_irq_enable && !halt_reset_option;
    endsequence

    sequence s_pulse_hold;
        reset_pin_oe [*8];
    endsequence

    property p_tick_spacing;
        pre.tick && tick_seen |-> since_tick == 16'(PRESCALE_CYCLES - 1);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing wrong");

    property p_expire_reset;
        expire && !reset_pin_oe |=> reset_pin_oe;
    endproperty
    a_expire_reset: assert property (p_expire_reset) else $error("no reset on expiry");

    property p_pulse_length;
        $rose(reset_pin_oe) |-> s_pulse_hold ##13 !reset_pin_oe;
    endproperty
    a_pulse_length: assert property (p_pulse_length) else $error("reset pulse length");

    property p_free_count;
        pre.tick && (state == st_run) && !ctrl_write |=> counter == 7'($past(counter) - 7'h01);
    endproperty
    a_free_count: assert property (p_free_count) else $error("counter did not step");

    property p_write_loads;
        ctrl_write |=> counter == $past(wb_dat_i[6:0]);
    endproperty
    a_write_loads: assert property (p_write_loads) else $error("write did not load");

    property p_activate_sticky;
        activate |=> activate;
    endproperty
    a_activate_sticky: assert property (p_activate_sticky) else $error("activation lost");

    property p_sw_reset;
        ctrl_write && wb_dat_i[ACTIVATE_BIT] && !wb_dat_i[TOP_BIT] |=> reset_pin_oe;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("software reset missed");

    property p_plain_halt;
        s_plain_halt |=> (state == st_halt_once) && !reset_pin_oe;
    endproperty
    a_plain_halt: assert property (p_plain_halt) else $error("plain halt wrong");

    property p_halted_frozen;
        (state == st_halted) && !ctrl_write |=> $stable(counter);
    endproperty
    a_halted_frozen: assert property (p_halted_frozen) else $error("halted counter moved");

    property p_halt_reset;
        halt_reset |=> reset_pin_oe;
    endproperty
    a_halt_reset: assert property (p_halt_reset) else $error("halt did not reset");

    property p_active_halt_wake;
        (state == st_active_halt) && osc_irq_wake |=> state == st_run;
    endproperty
    a_active_halt_wake: assert property (p_active_halt_wake) else $error("wake missed");

    property p_startup_short;
        (state == st_startup) && !startup_long_select |-> startup_count <= STARTUP_S_END;
    endproperty
    a_startup_short: assert property (p_startup_short) else $error("startup overrun");

endmodule : software_fault_watchdog

//--- logic/watchdog_pkg.sv
package watchdog_pkg;

    localparam logic [7:0]  CTRL_ADDR          = 8'h24;
    localparam logic [7:0]  STATUS_ADDR        = 8'h28;
    localparam logic [7:0]  CTRL_RESET         = 8'h7f;
    localparam int          ACTIVATE_BIT       = 7;
    localparam int          TOP_BIT            = 6;
    localparam logic [6:0]  COUNTER_TRIGGER    = 7'h40;
    localparam int          PRESCALE_DEFAULT   = 16384;
    localparam int          CLOCK_PERIOD_NS    = 25;
    localparam int          RESET_PULSE_NS     = 500;
    localparam int          RESET_PULSE_RAW    = RESET_PULSE_NS / CLOCK_PERIOD_NS;
    localparam int          RESET_PULSE_CYCLES = (RESET_PULSE_RAW < 1) ? 1 : RESET_PULSE_RAW;
    localparam int          STARTUP_SHORT      = 256;
    localparam int          STARTUP_LONG       = 4096;
    localparam int          STAT_ACTIVE        = 0;
    localparam int          STAT_HALTED        = 1;
    localparam int          STAT_STARTUP       = 2;
    localparam int          STAT_PIN_LEVEL     = 3;
    localparam int          STAT_PULSE         = 4;

    typedef enum logic [4:0] {
        st_startup     = 5'b00001,
        st_run         = 5'b00010,
        st_halt_once   = 5'b00100,
        st_halted      = 5'b01000,
        st_active_halt = 5'b10000
    } state_type;

endpackage : watchdog_pkg

//--- logic/watchdog_prescaler.sv
`timescale 1ns/1ps
module watchdog_prescaler #(
    parameter int PRESCALE_CYCLES = 16384
) (
    input  wire logic clock,
    input  wire logic rst,
    prescale_if.source pre
);
    localparam int W = (PRESCALE_CYCLES < 2) ? 1 : $clog2(PRESCALE_CYCLES);
    localparam logic [W-1:0] LAST = W'(PRESCALE_CYCLES - 1);

    logic [W-1:0] count;

    if (PRESCALE_CYCLES < 2) begin : g_bad_prescale
        $error("prescaler needs at least two cycles");
    end

    // Free running: nothing but system reset clears it
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= '0;
        end else if (count == LAST) begin
            count <= '0;
        end else begin
            count <= count + W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pre.tick <= 1'b0;
        end else begin
            pre.tick <= (count == LAST);
        end
    end

endmodule : watchdog_prescaler

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import watchdog_pkg::*;
    logic        clock  = 1'b0;
    logic        rst    = 1'b1;
    logic        cyc    = 1'b0;
    logic        stb    = 1'b0;
    logic        we     = 1'b0;
    logic [7:0]  adr    = 8'h00;
    logic [7:0]  wdat   = 8'h00;
    logic        halt   = 1'b0;
    logic        ext_w  = 1'b0;
    logic        osc_w  = 1'b0;
    logic        rtc_en = 1'b0;
    logic        hw_opt = 1'b0;
    logic        hr_opt = 1'b0;
    logic        long_sel = 1'b0;
    logic        pin_in = 1'b1;
    logic [31:0] rdat;
    logic        ack;
    logic        pin_o;
    logic        pin_oe;
    logic        halted;
    logic [7:0]  v0;
    logic [7:0]  v1;
    int          error_cnt   = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    int          oe_cnt      = 0;
    int          n;
    int          w;

    // Short prescale keeps each tick at 16 cycles
    software_fault_watchdog #(.PRESCALE_CYCLES(16)) i_software_fault_watchdog (
        .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wdat}), .wb_dat_o(rdat),
        .wb_ack_o(ack), .halt_exec(halt), .ext_irq_wake(ext_w), .osc_irq_wake(osc_w),
        .rtc_irq_enable(rtc_en), .hw_watchdog_option(hw_opt), .halt_reset_option(hr_opt),
        .startup_long_select(long_sel), .reset_pin_i(pin_in), .reset_pin_o(pin_o),
        .reset_pin_oe(pin_oe), .watchdog_halted(halted));

    always #12.5 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (pin_oe === 1'b1) oe_cnt++;
        if (cycles > 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task check(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Request held until ack is sampled high; only the bench timeout ends a wait
    task bus(input logic wr_en, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= wr_en;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : bus

    task rd(input logic [7:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask : rd

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] t;
        bus(1'b1, a, d, t);
    endtask : wr

    task do_reset;
        @(posedge clock);
        rst <= 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
    endtask : do_reset

    // Selects 0 halt, 1 external wake, 2 oscillator wake
    task pulse(input int which);
        @(posedge clock);
        case (which)
            0: halt <= 1'b1;
            1: ext_w <= 1'b1;
            default: osc_w <= 1'b1;
        endcase
        @(posedge clock);
        halt  <= 1'b0;
        ext_w <= 1'b0;
        osc_w <= 1'b0;
    endtask : pulse

    task wait_oe(input int lim);
        n = 0;
        while (pin_oe !== 1'b1 && n < lim) begin
            @(posedge clock);
            n++;
        end
    endtask : wait_oe

    // Reads spaced exactly four ticks apart
    task read_pair;
        rd(CTRL_ADDR, v0);
        repeat (61) @(posedge clock);
        rd(CTRL_ADDR, v1);
    endtask : read_pair

    task t_reset_state;
        do_reset();
        pin_in <= 1'b0;
        read_pair();
        check("ctrl reset", v0, CTRL_RESET);
        check("startup freeze", v1, CTRL_RESET);
        rd(STATUS_ADDR, v0);
        check("inactive", {7'h0, v0[0]}, 8'h00);
        check("status at start", v0, 8'h04);
        pin_in <= 1'b1;
        wr(CTRL_ADDR, 8'hff);
        wr(CTRL_ADDR, 8'h7f);
        rd(CTRL_ADDR, v0);
        check("sticky activation", {7'h0, v0[7]}, 8'h01);
        rd(8'hfc, v0);
        check("unmapped", v0, 8'h00);
    endtask : t_reset_state

    task t_free_run;
        do_reset();
        repeat (300) @(posedge clock);
        // Inactive, so the 40h to 3Fh step must pass quietly
        wr(CTRL_ADDR, 8'h41);
        w = oe_cnt;
        read_pair();
        check("free count", v1, v0 - 8'h04);
        check("crossed 40h", {7'h0, v1[6]}, 8'h00);
        check("no reset when off", 8'(oe_cnt - w), 8'h00);
    endtask : t_free_run

    task t_expiry(input int k);
        do_reset();
        repeat (300) @(posedge clock);
        wr(CTRL_ADDR, 8'hc0 | 8'(k));
        wait_oe(2000);
        check("expiry time", 8'(n >= 16 * k + 2 && n <= 16 * k + 18), 8'h01);
        check("pin low", {7'h0, pin_o}, 8'h00);
        w = 0;
        while (pin_oe === 1'b1 && w < 40) begin
            @(posedge clock);
            w++;
        end
        check("pulse width", 8'(w), 8'(RESET_PULSE_CYCLES));
    endtask : t_expiry

    task t_soft_reset;
        do_reset();
        repeat (300) @(posedge clock);
        wr(CTRL_ADDR, 8'h85);
        wait_oe(5);
        check("software reset", 8'(n < 5), 8'h01);
        rd(STATUS_ADDR, v0);
        check("pulse status", v0, 8'h19);
    endtask : t_soft_reset

    task t_hw_option;
        hw_opt <= 1'b1;
        do_reset();
        rd(CTRL_ADDR, v0);
        check("hw ctrl", v0, 8'hff);
        // Counter stays frozen through start-up, so let it pass first
        repeat (300) @(posedge clock);
        wr(CTRL_ADDR, 8'h41);
        wait_oe(100);
        check("hw expiry", 8'(n < 100), 8'h01);
        hw_opt <= 1'b0;
    endtask : t_hw_option

    task t_halt_plain;
        do_reset();
        repeat (300) @(posedge clock);
        wr(CTRL_ADDR, 8'hc5);
        pulse(0);
        repeat (40) @(posedge clock);
        check("halted", {7'h0, halted}, 8'h01);
        w = oe_cnt;
        rd(CTRL_ADDR, v0);
        check("one step", 8'(v0 < 8'hc5), 8'h01);
        repeat (200) @(posedge clock);
        rd(CTRL_ADDR, v1);
        check("halt frozen", v1, v0);
        check("no halt reset", 8'(oe_cnt - w), 8'h00);
        pulse(1);
        repeat (100) @(posedge clock);
        rd(CTRL_ADDR, v1);
        check("wake delay", v1, v0);
        wait_oe(600);
        check("resumed", 8'(n > 100 && n < 600), 8'h01);
    endtask : t_halt_plain

    task t_halt_reset;
        do_reset();
        repeat (300) @(posedge clock);
        hr_opt <= 1'b1;
        wr(CTRL_ADDR, 8'hff);
        pulse(0);
        wait_oe(5);
        check("halt reset", 8'(n < 5), 8'h01);
        check("no halt entry", {7'h0, halted}, 8'h00);
        hr_opt <= 1'b0;
    endtask : t_halt_reset

    task t_active_halt;
        do_reset();
        repeat (300) @(posedge clock);
        rtc_en <= 1'b1;
        wr(CTRL_ADDR, 8'hff);
        pulse(0);
        repeat (4) @(posedge clock);
        rd(CTRL_ADDR, v0);
        repeat (200) @(posedge clock);
        rd(CTRL_ADDR, v1);
        check("active halt frozen", v1, v0);
        pulse(2);
        read_pair();
        check("immediate restart", v1, v0 - 8'h04);
        rtc_en <= 1'b0;
    endtask : t_active_halt

    task t_long_startup;
        long_sel <= 1'b1;
        do_reset();
        repeat (3000) @(posedge clock);
        rd(CTRL_ADDR, v0);
        check("long start frozen", v0, CTRL_RESET);
        repeat (1200) @(posedge clock);
        rd(CTRL_ADDR, v1);
        check("long start ends", 8'(v1 < CTRL_RESET), 8'h01);
        long_sel <= 1'b0;
    endtask : t_long_startup

    initial begin
        do_reset();
        t_reset_state();
        $display("reset state done");
        t_free_run();
        $display("free run done");
        t_expiry(0);
        t_expiry(5);
        $display("expiry done");
        t_soft_reset();
        $display("software reset done");
        t_hw_option();
        $display("hardware option done");
        t_halt_plain();
        $display("plain halt done");
        t_halt_reset();
        $display("halt reset done");
        t_active_halt();
        $display("active halt done");
        t_long_startup();
        $display("long start-up done");
        complete_run();
    end
endmodule : tb
